//--- tifs_pkg.sv
// Constants for the counter initial value and channel flag summary block.
// Assumes a 32-bit APB slave with word-aligned registers.
package tifs_pkg;
   // Register byte addresses
   localparam logic [11:0] ADDR_INIT_HIGH  = 12'h000;
   localparam logic [11:0] ADDR_INIT_LOW   = 12'h004;
   localparam logic [11:0] ADDR_FLAG_SUM   = 12'h008;
   localparam logic [11:0] ADDR_IRQ_STAT   = 12'h00C;
   localparam logic [11:0] ADDR_IRQ_MASK   = 12'h010;
   localparam logic [11:0] ADDR_STATE      = 12'h014;
   // Reset values
   localparam logic [15:0] INIT_RESET     = 16'h0000;
   localparam logic [7:0]  FLAG_RESET     = 8'h00;
   localparam logic [7:0]  MASK_RESET     = 8'h00;
   localparam logic [31:0] RDATA_UNMAPPED = 32'h0000_0000;
   // State register fields
   localparam int STATE_CLK_STARTED = 0;
   localparam int STATE_LO_LATCHED  = 1;
   localparam int STATE_HI_LATCHED  = 2;
   // Channel mode codes
   localparam logic [2:0] MODE_OFF     = 3'h0;
   localparam logic [2:0] MODE_CAPTURE = 3'h1;
   localparam logic [2:0] MODE_COMPARE = 3'h2;
   localparam logic [2:0] MODE_EPWM    = 3'h3;
   localparam logic [2:0] MODE_CPWM    = 3'h4;
   localparam logic [2:0] MODE_COMBINE = 3'h5;
   // Register selector
   typedef enum {
      SEL_INIT_HIGH,
      SEL_INIT_LOW,
      SEL_FLAG_SUM,
      SEL_IRQ_STAT,
      SEL_IRQ_MASK,
      SEL_STATE,
      SEL_NONE
   } tifs_sel_e;
endpackage

//--- tifs_wr_if.sv
// Byte write path between the register slave and the coherency buffer.
// Assumes both ends sit on the same clock.
`timescale 1ns/10ps
interface tifs_wr_if;
   logic        byteWe;
   logic        byteHigh;
   logic [7:0]  byteData;
   logic        debugHalt;
   logic [15:0] value;
   logic        hiLatched;
   logic        loLatched;
   modport host (output byteWe, output byteHigh, output byteData, output debugHalt,
                 input value, input hiLatched, input loLatched);
   modport buffer (input byteWe, input byteHigh, input byteData, input debugHalt,
                   output value, output hiLatched, output loLatched);
endinterface

//--- tifs_coh_buf.sv
// Two-byte write coherency buffer for the counter initial value.
// Assumes one byte write per cycle at most, qualified by the caller.
`timescale 1ns/10ps
module tifs_coh_buf (
   // Clock and reset
   input wire logic   clk,
   input wire logic   sys_rst,
   input wire logic   clkEn,
   // Write path
   tifs_wr_if.buffer  wr
);
   logic [15:0] value_q,  value_d;
   logic [15:0] hold_q,   hold_d;
   logic        hiLat_q,  hiLat_d;
   logic        loLat_q,  loLat_d;

   always_comb begin
      value_d = value_q;
      hold_d  = hold_q;
      hiLat_d = hiLat_q;
      loLat_d = loLat_q;
      if (wr.byteWe) begin
         if (wr.debugHalt) begin
            // Latches stay frozen; byte goes straight to the register
            if (wr.byteHigh) begin
               value_d[15:8] = wr.byteData;
            end else begin
               value_d[7:0] = wr.byteData;
            end
         end else if (wr.byteHigh) begin
            hold_d[15:8] = wr.byteData;
            if (loLat_q) begin
               value_d = {wr.byteData, hold_q[7:0]};
               loLat_d = 1'b0;
            end else begin
               hiLat_d = 1'b1;
            end
         end else begin
            hold_d[7:0] = wr.byteData;
            if (hiLat_q) begin
               value_d = {hold_q[15:8], wr.byteData};
               hiLat_d = 1'b0;
            end else begin
               loLat_d = 1'b1;
            end
         end
      end
   end

   // Latch flags and holding bytes only move outside debug halt
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         value_q <= tifs_pkg::INIT_RESET;
         hold_q  <= tifs_pkg::INIT_RESET;
         hiLat_q <= 1'b0;
         loLat_q <= 1'b0;
      end else if (clkEn) begin
         value_q <= value_d;
         hold_q  <= hold_d;
         hiLat_q <= hiLat_d;
         loLat_q <= loLat_d;
      end
   end

   assign wr.value     = value_q;
   assign wr.hiLatched = hiLat_q;
   assign wr.loLatched = loLat_q;
endmodule

//--- tifs_top.sv
// Counter initial value register and channel flag summary, APB slave.
// Assumes all timer-side inputs are on clk; pready answers in the access cycle.
//
// Local design decisions: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
module tifs_top #(
   parameter int CHANNELS = 8
) (
   // Clock and reset
   input  wire logic                  clk,
   input  wire logic                  sys_rst,
   input  wire logic                  clkEn,
   // APB slave
   input  wire logic                  psel,
   input  wire logic                  penable,
   input  wire logic                  pwrite,
   input  wire logic [11:0]           paddr,
   input  wire logic [31:0]           pwdata,
   output logic      [31:0]           prdata,
   output logic                       pready,
   output logic                       pslverr,
   // Timer side
   input  wire logic                  debugHalt,
   input  wire logic [1:0]            clockSourceSelect,
   input  wire logic                  counterWritten,
   input  wire logic [CHANNELS-1:0]   chanCaptureEdge,
   input  wire logic [CHANNELS-1:0]   chanMatch,
   input  wire logic [CHANNELS-1:0]   chanDutyExtreme,
   input  wire logic [3*CHANNELS-1:0] chanMode,
   // Results
   output logic      [15:0]           counterInitialValue,
   output logic                       counterStartZero,
   output logic      [CHANNELS-1:0]   channelEventFlag,
   output logic                       irq
);
   tifs_wr_if wr ();

   tifs_coh_buf u_buf (
      .clk     (clk),
      .sys_rst (sys_rst),
      .clkEn   (clkEn),
      .wr      (wr)
   );

   function automatic tifs_pkg::tifs_sel_e regSel(input logic [11:0] a);
      case (a)
         tifs_pkg::ADDR_INIT_HIGH: regSel = tifs_pkg::SEL_INIT_HIGH;
         tifs_pkg::ADDR_INIT_LOW:  regSel = tifs_pkg::SEL_INIT_LOW;
         tifs_pkg::ADDR_FLAG_SUM:  regSel = tifs_pkg::SEL_FLAG_SUM;
         tifs_pkg::ADDR_IRQ_STAT:  regSel = tifs_pkg::SEL_IRQ_STAT;
         tifs_pkg::ADDR_IRQ_MASK:  regSel = tifs_pkg::SEL_IRQ_MASK;
         tifs_pkg::ADDR_STATE:     regSel = tifs_pkg::SEL_STATE;
         default:                  regSel = tifs_pkg::SEL_NONE;
      endcase
   endfunction

   // Set request of one channel from its mode and timer events
   function automatic logic chanEvent(input logic [2:0] mode, input logic edgeSeen,
                                      input logic match, input logic dutyExtreme);
      case (mode)
         tifs_pkg::MODE_CAPTURE: chanEvent = edgeSeen;
         tifs_pkg::MODE_COMPARE: chanEvent = match;
         tifs_pkg::MODE_EPWM:    chanEvent = match && !dutyExtreme;
         tifs_pkg::MODE_CPWM:    chanEvent = match && !dutyExtreme;
         tifs_pkg::MODE_COMBINE: chanEvent = match;
         default:                chanEvent = 1'b0;
      endcase
   endfunction

   // Bus state
   logic [31:0]         prdata_q,  prdata_d;
   logic                pready_q,  pready_d;
   logic                pslverr_q, pslverr_d;
   // Flag state
   logic [CHANNELS-1:0] flag_q,    flag_d;
   logic [CHANNELS-1:0] armed_q,   armed_d;
   logic [CHANNELS-1:0] stat_q,    stat_d;
   logic [CHANNELS-1:0] mask_q,    mask_d;
   logic                irq_q,     irq_d;
   // Counter start state
   logic                started_q, started_d;
   logic                cntInit_q, cntInit_d;
   logic                zero_q,    zero_d;
   logic [15:0]         initOut_q;

   logic                access;
   logic                wrAcc;
   logic                rdAcc;
   tifs_pkg::tifs_sel_e sel;
   logic [CHANNELS-1:0] setReq;

   assign sel    = regSel(paddr);
   assign access = psel && penable && pready_q;
   assign wrAcc  = access && pwrite;
   assign rdAcc  = access && !pwrite;

   always_comb begin
      for (int i = 0; i < CHANNELS; i++) begin
         setReq[i] = chanEvent(chanMode[3*i +: 3], chanCaptureEdge[i], chanMatch[i], chanDutyExtreme[i]);
      end
   end

   // Byte writes to the initial value go through the coherency buffer
   always_comb begin
      wr.byteWe    = wrAcc && (sel == tifs_pkg::SEL_INIT_HIGH || sel == tifs_pkg::SEL_INIT_LOW);
      wr.byteHigh  = (sel == tifs_pkg::SEL_INIT_HIGH);
      wr.byteData  = pwdata[7:0];
      wr.debugHalt = debugHalt;
   end

   // APB: read data prepared in setup, presented in access
   always_comb begin
      pready_d  = psel && !penable;
      pslverr_d = psel && !penable && (sel == tifs_pkg::SEL_NONE);
      prdata_d  = tifs_pkg::RDATA_UNMAPPED;
      if (psel && !penable && !pwrite) begin
         case (sel)
            tifs_pkg::SEL_INIT_HIGH: prdata_d[7:0] = wr.value[15:8];
            tifs_pkg::SEL_INIT_LOW:  prdata_d[7:0] = wr.value[7:0];
            tifs_pkg::SEL_FLAG_SUM:  prdata_d[CHANNELS-1:0] = flag_q;
            tifs_pkg::SEL_IRQ_STAT:  prdata_d[CHANNELS-1:0] = stat_q;
            tifs_pkg::SEL_IRQ_MASK:  prdata_d[CHANNELS-1:0] = mask_q;
            tifs_pkg::SEL_STATE: begin
               prdata_d[tifs_pkg::STATE_CLK_STARTED] = started_q;
               prdata_d[tifs_pkg::STATE_LO_LATCHED]  = wr.loLatched;
               prdata_d[tifs_pkg::STATE_HI_LATCHED]  = wr.hiLatched;
            end
            default:                 prdata_d = tifs_pkg::RDATA_UNMAPPED;
         endcase
      end
   end

   // Flags: read arms the clear, a zero write completes it, a new set wins
   always_comb begin
      flag_d  = flag_q;
      armed_d = armed_q;
      if (rdAcc && sel == tifs_pkg::SEL_FLAG_SUM) begin
         armed_d = armed_q | prdata_q[CHANNELS-1:0];
      end
      if (wrAcc && sel == tifs_pkg::SEL_FLAG_SUM) begin
         // Ones written leave a flag alone; zeros clear only armed flags
         flag_d  = flag_q & ~(armed_q & ~pwdata[CHANNELS-1:0]);
         armed_d = armed_q & pwdata[CHANNELS-1:0];
      end
      flag_d  = flag_d | setReq;
      armed_d = armed_d & ~setReq;
   end

   // Interrupt status: sticky on each set request, cleared by a read
   always_comb begin
      stat_d = stat_q;
      mask_d = mask_q;
      if (rdAcc && sel == tifs_pkg::SEL_IRQ_STAT) begin
         stat_d = stat_q & ~prdata_q[CHANNELS-1:0];
      end
      stat_d = stat_d | setReq;
      if (wrAcc && sel == tifs_pkg::SEL_IRQ_MASK) begin
         mask_d = pwdata[CHANNELS-1:0];
      end
      irq_d = |(stat_d & mask_d);
   end

   // Counter start: zero on first clock selection unless initialised first
   always_comb begin
      started_d = started_q;
      cntInit_d = cntInit_q | counterWritten;
      zero_d    = 1'b0;
      if (!started_q && clockSourceSelect != 2'b00) begin
         started_d = 1'b1;
         zero_d    = !cntInit_d;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         prdata_q  <= tifs_pkg::RDATA_UNMAPPED;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         flag_q    <= tifs_pkg::FLAG_RESET;
         armed_q   <= tifs_pkg::FLAG_RESET;
         stat_q    <= tifs_pkg::FLAG_RESET;
         mask_q    <= tifs_pkg::MASK_RESET;
         irq_q     <= 1'b0;
         started_q <= 1'b0;
         cntInit_q <= 1'b0;
         zero_q    <= 1'b0;
         initOut_q <= tifs_pkg::INIT_RESET;
      end else if (clkEn) begin
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         flag_q    <= flag_d;
         armed_q   <= armed_d;
         stat_q    <= stat_d;
         mask_q    <= mask_d;
         irq_q     <= irq_d;
         started_q <= started_d;
         cntInit_q <= cntInit_d;
         zero_q    <= zero_d;
         // Extra stage keeps the output on a flop; one cycle behind the register
         initOut_q <= wr.value;
      end
   end

   assign prdata              = prdata_q;
   assign pready              = pready_q;
   assign pslverr             = pslverr_q;
   assign counterInitialValue = initOut_q;
   assign counterStartZero    = zero_q;
   assign channelEventFlag    = flag_q;
   assign irq                 = irq_q;
endmodule

//--- tifs_top_assertions.sv
// Port checks for the initial value and flag summary block.
// Assumes every port is on clk; bound from the testbench top.
`timescale 1ns/10ps
module tifs_top_assertions #(
   parameter int CHANNELS = 8
) (
   // Clock and reset
   input wire logic                  clk,
   input wire logic                  sys_rst,
   input wire logic                  clkEn,
   // APB
   input wire logic                  psel,
   input wire logic                  penable,
   input wire logic                  pwrite,
   input wire logic [11:0]           paddr,
   input wire logic [31:0]           pwdata,
   input wire logic [31:0]           prdata,
   input wire logic                  pready,
   input wire logic                  pslverr,
   // Timer side
   input wire logic                  debugHalt,
   input wire logic [1:0]            clockSourceSelect,
   input wire logic                  counterWritten,
   input wire logic [CHANNELS-1:0]   chanCaptureEdge,
   input wire logic [CHANNELS-1:0]   chanMatch,
   input wire logic [CHANNELS-1:0]   chanDutyExtreme,
   input wire logic [3*CHANNELS-1:0] chanMode,
   // Results
   input wire logic [15:0]           counterInitialValue,
   input wire logic                  counterStartZero,
   input wire logic [CHANNELS-1:0]   channelEventFlag,
   input wire logic                  irq
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   sequence s_setup;
      psel && !penable && clkEn;
   endsequence
   sequence s_access;
      psel && penable && clkEn;
   endsequence
   a_ready_in_access: assert property (s_setup ##1 s_access |-> pready)
      else $error("pready missing in access cycle");
   a_reset_clears: assert property (disable iff (1'b0) sys_rst && clkEn |=> channelEventFlag == '0)
      else $error("flags not cleared by reset");
   a_capture_sets: assert property (clkEn && chanMode[2:0] == 3'h1 && chanCaptureEdge[0] |=> channelEventFlag[0])
      else $error("capture edge did not set flag");
   a_compare_sets: assert property (clkEn && chanMode[5:3] == 3'h2 && chanMatch[1] |=> channelEventFlag[1])
      else $error("compare match did not set flag");
   a_extreme_duty_quiet: assert property (chanMode[17:15] == 3'h3 && chanDutyExtreme[5] && !channelEventFlag[5]
      |=> !channelEventFlag[5])
      else $error("flag set at extreme duty");
   a_combine_sets: assert property (clkEn && chanMode[20:18] == 3'h5 && chanMatch[6] |=> channelEventFlag[6])
      else $error("combine match did not set flag");
   a_clear_by_write: assert property (|($past(channelEventFlag) & ~channelEventFlag)
      |-> $past(psel && penable && pwrite && paddr == tifs_pkg::ADDR_FLAG_SUM))
      else $error("flag cleared without summary write");
   a_summary_copy: assert property (pready && !pwrite && paddr == tifs_pkg::ADDR_FLAG_SUM
      |-> prdata[CHANNELS-1:0] == $past(channelEventFlag))
      else $error("summary read differs from flags");
   a_start_zero_pulse: assert property (counterStartZero |-> $past(clockSourceSelect) != 2'b00 ##1 !counterStartZero)
      else $error("bad start-from-zero pulse");
   a_init_commit: assert property ($changed(counterInitialValue)
      |-> $past(psel && penable && pwrite && paddr <= tifs_pkg::ADDR_INIT_LOW, 2))
      else $error("initial value changed without write");
endmodule

//--- test_tifs_top.sv
// Testbench for the initial value and flag summary block.
// Assumes a 10 MHz clock and an APB master inside this module.
`timescale 1ns/10ps
module test_tifs_top;
   localparam int CHANNELS = 8;
   logic        clk = 1'b0, sys_rst = 1'b1, clkEn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        debugHalt = 1'b0, counterWritten = 1'b0, pready, pslverr, counterStartZero, irq, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic [1:0]  clockSourceSelect = 2'b00;
   logic [7:0]  chanCaptureEdge = 8'h00, chanMatch = 8'h00, chanDutyExtreme = 8'h00, channelEventFlag;
   logic [23:0] chanMode = 24'h00_0000;
   logic [15:0] counterInitialValue;
   int          errorCnt = 0, checksDone = 0, zeroPulses = 0;
   tifs_top #(.CHANNELS(CHANNELS)) dut (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .debugHalt(debugHalt), .clockSourceSelect(clockSourceSelect),
      .counterWritten(counterWritten), .chanCaptureEdge(chanCaptureEdge), .chanMatch(chanMatch),
      .chanDutyExtreme(chanDutyExtreme), .chanMode(chanMode), .counterInitialValue(counterInitialValue),
      .counterStartZero(counterStartZero), .channelEventFlag(channelEventFlag), .irq(irq));
   initial begin
      forever #50 clk = ~clk;
   end
   always @(negedge clk) begin
      if (counterStartZero === 1'b1) zeroPulses++;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checksDone++;
      if (seen !== exp) begin
         errorCnt++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Waits on pready itself; the slave latency is never assumed
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // Pready and read data are taken at the very edge that ends the access
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) errorCnt++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(rd, exp);
   endtask
   task automatic settle();
      repeat (2) @(negedge clk);
   endtask
   task automatic finalReport();
      $display("Checks %0d, mismatches %0d", checksDone, errorCnt);
      if (errorCnt == 0 && checksDone > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #5_000_000;
      errorCnt++;
      finalReport();
   end
   initial begin
      repeat (12) @(posedge clk);
      sys_rst <= 1'b0;
      rdChk(tifs_pkg::ADDR_INIT_HIGH, 32'h0000_0000);
      rdChk(tifs_pkg::ADDR_FLAG_SUM, 32'h0000_0000);
      rdChk(tifs_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
      rdChk(12'h020, 32'h0000_0000);
      chk(32'(err), 32'h0000_0001);
      apb(1'b1, tifs_pkg::ADDR_INIT_HIGH, 32'h0000_0012);
      settle();
      chk(32'(counterInitialValue), 32'h0000_0000);
      apb(1'b1, tifs_pkg::ADDR_INIT_LOW, 32'h0000_0034);
      settle();
      chk(32'(counterInitialValue), 32'h0000_1234);
      rdChk(tifs_pkg::ADDR_INIT_HIGH, 32'h0000_0012);
      // High byte held, then a halt arrives mid-sequence
      apb(1'b1, tifs_pkg::ADDR_INIT_HIGH, 32'h0000_00ab);
      debugHalt <= 1'b1;
      apb(1'b1, tifs_pkg::ADDR_INIT_LOW, 32'h0000_0055);
      settle();
      chk(32'(counterInitialValue), 32'h0000_1255);
      rdChk(tifs_pkg::ADDR_STATE, 32'h0000_0004);
      @(posedge clk);
      debugHalt <= 1'b0;
      apb(1'b1, tifs_pkg::ADDR_INIT_LOW, 32'h0000_00cd);
      settle();
      chk(32'(counterInitialValue), 32'h0000_abcd);
      @(posedge clk);
      counterWritten <= 1'b1;
      @(posedge clk);
      counterWritten <= 1'b0;
      clockSourceSelect <= 2'b01;
      repeat (3) @(negedge clk);
      chk(zeroPulses, 32'h0000_0000);
      @(posedge clk);
      clockSourceSelect <= 2'b00;
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      clockSourceSelect <= 2'b10;
      repeat (3) @(posedge clk);
      clockSourceSelect <= 2'b00;
      repeat (3) @(posedge clk);
      clockSourceSelect <= 2'b01;
      repeat (3) @(negedge clk);
      chk(zeroPulses, 32'h0000_0001);
      apb(1'b1, tifs_pkg::ADDR_IRQ_MASK, 32'h0000_0001);
      chk(32'(irq), 32'h0000_0000);
      chanMode <= {tifs_pkg::MODE_OFF, tifs_pkg::MODE_COMBINE, tifs_pkg::MODE_EPWM, tifs_pkg::MODE_COMBINE,
                   tifs_pkg::MODE_CPWM, tifs_pkg::MODE_EPWM, tifs_pkg::MODE_COMPARE, tifs_pkg::MODE_CAPTURE};
      // Extreme duty on both PWM flavours and on one combine channel
      chanDutyExtreme <= 8'h68;
      @(posedge clk);
      chanCaptureEdge <= 8'hff;
      chanMatch <= 8'hff;
      @(posedge clk);
      chanCaptureEdge <= 8'h00;
      chanMatch <= 8'h00;
      settle();
      chk(32'(channelEventFlag), 32'h0000_0057);
      chk(32'(irq), 32'h0000_0001);
      rdChk(tifs_pkg::ADDR_IRQ_STAT, 32'h0000_0057);
      rdChk(tifs_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
      chk(32'(irq), 32'h0000_0000);
      apb(1'b1, tifs_pkg::ADDR_FLAG_SUM, 32'h0000_00ff);
      apb(1'b1, tifs_pkg::ADDR_FLAG_SUM, 32'h0000_0000);
      settle();
      chk(32'(channelEventFlag), 32'h0000_0057);
      rdChk(tifs_pkg::ADDR_FLAG_SUM, 32'h0000_0057);
      // Ones written to armed flags must leave them set
      apb(1'b1, tifs_pkg::ADDR_FLAG_SUM, 32'h0000_00ff);
      settle();
      chk(32'(channelEventFlag), 32'h0000_0057);
      @(posedge clk);
      chanCaptureEdge <= 8'h01;
      @(posedge clk);
      chanCaptureEdge <= 8'h00;
      apb(1'b1, tifs_pkg::ADDR_FLAG_SUM, 32'h0000_0000);
      settle();
      chk(32'(channelEventFlag), 32'h0000_0001);
      rdChk(tifs_pkg::ADDR_FLAG_SUM, 32'h0000_0001);
      apb(1'b1, tifs_pkg::ADDR_FLAG_SUM, 32'h0000_0000);
      settle();
      chk(32'(channelEventFlag), 32'h0000_0000);
      // A match while the clock enable is low is lost
      @(posedge clk);
      clkEn <= 1'b0;
      chanMatch <= 8'h02;
      @(posedge clk);
      clkEn <= 1'b1;
      chanMatch <= 8'h00;
      settle();
      chk(32'(channelEventFlag), 32'h0000_0000);
      finalReport();
   end
endmodule
bind tifs_top tifs_top_assertions #(.CHANNELS(CHANNELS)) chk_u (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .debugHalt(debugHalt), .clockSourceSelect(clockSourceSelect),
   .counterWritten(counterWritten), .chanCaptureEdge(chanCaptureEdge), .chanMatch(chanMatch),
   .chanDutyExtreme(chanDutyExtreme), .chanMode(chanMode), .counterInitialValue(counterInitialValue),
   .counterStartZero(counterStartZero), .channelEventFlag(channelEventFlag), .irq(irq));
